// ---- pcds_pkg.sv ----
`default_nettype none
package pcds_pkg;

    // management station addressing
    localparam logic [4:0] PHY_ADDR_1     = 5'h01;
    localparam logic [4:0] PHY_ADDR_2     = 5'h02;
    localparam logic [4:0] REG_PARTNER    = 5'h05;
    localparam logic [4:0] REG_CABLE_DIAG = 5'h1D;
    localparam logic [4:0] REG_SPECIAL    = 5'h1F;

    // management frame fields
    localparam logic [5:0] PREAMBLE_LEN   = 6'h20;
    localparam logic [1:0] OP_WRITE       = 2'h1;
    localparam logic [1:0] OP_READ        = 2'h2;
    localparam logic [4:0] OP_BITS        = 5'h02;
    localparam logic [4:0] ADDR_BITS      = 5'h0A;
    localparam logic [4:0] DATA_BITS      = 5'h10;

    // partner ability field positions
    localparam int PARTNER_PAUSE_POS      = 10;
    localparam int PARTNER_ABIL_LSB       = 5;

    // cable diagnostic field positions
    localparam int DIAG_START_POS         = 15;
    localparam int DIAG_OUTCOME_LSB       = 13;
    localparam int DIAG_SHORT_POS         = 12;
    localparam int DIAG_COUNT_LSB         = 0;

    // special register field positions
    localparam int SPEC_POLARITY_POS      = 5;
    localparam int SPEC_MDI_POS           = 4;
    localparam int SPEC_FORCE_LINK_POS    = 3;
    localparam int SPEC_PWR_SAVE_OFF_POS  = 2;
    localparam int SPEC_REMOTE_LOOP_POS   = 1;
    localparam int SPEC_RESERVED_POS      = 0;

    // reset values
    localparam logic [1:0] OUTCOME_RESET       = 2'h0;
    localparam logic [8:0] FAULT_COUNT_RESET   = 9'h000;
    localparam logic       PWR_SAVE_OFF_RESET  = 1'b1;

    // test outcome codes
    localparam logic [1:0] OUTCOME_NORMAL = 2'h0;
    localparam logic [1:0] OUTCOME_OPEN   = 2'h1;
    localparam logic [1:0] OUTCOME_SHORT  = 2'h2;
    localparam logic [1:0] OUTCOME_FAILED = 2'h3;

    // per-phy line state from the analog side
    typedef struct packed {
        logic       partner_pause;
        logic [3:0] partner_abil;   // 100f, 100h, 10f, 10h
        logic       pol_reversed;
        logic       mdi_status;
    } pcds_status_s;

    // result of one cable measurement
    typedef struct packed {
        logic [1:0] outcome;
        logic       short_near_flag;
        logic [8:0] fault_count;
    } pcds_diag_s;

    // per-phy controls driven into the phy
    typedef struct packed {
        logic force_link;
        logic power_save_en;
        logic remote_loopback;
    } pcds_ctrl_s;

endpackage
`default_nettype wire

// ---- pcds_phy_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcds_phy_bank (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  wr_in,
    input  wire logic [4:0]            register_select_in,
    input  wire logic [15:0]           wdata_in,
    input  wire pcds_pkg::pcds_status_s status_in,
    input  wire pcds_pkg::pcds_diag_s   diag_in,
    input  wire logic                  diag_done_in,
    output logic [15:0]                rd_data_out,
    output pcds_pkg::pcds_ctrl_s        ctrl_out,
    output logic                       diag_start_out
);

    logic                test_running;
    pcds_pkg::pcds_diag_s diag_held;
    logic                force_link;
    logic                pwr_save_off;
    logic                remote_loop;
    logic                reserved_bit;
    logic                wr_diag;
    logic                wr_special;

    assign wr_diag    = wr_in && (register_select_in == pcds_pkg::REG_CABLE_DIAG);
    assign wr_special = wr_in && (register_select_in == pcds_pkg::REG_SPECIAL);

    ////////////////////////////////////////////////////////////////////////////
    // cable test launch and self-clear
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            test_running   <= 1'b0;
            diag_start_out <= 1'b0;
        end else begin
            diag_start_out <= 1'b0;
            if (!test_running && wr_diag && wdata_in[pcds_pkg::DIAG_START_POS]) begin
                test_running   <= 1'b1;
                diag_start_out <= 1'b1;
            end else if (test_running && diag_done_in) begin
                test_running <= 1'b0;
            end
        end
    end

    // results held until a test completes
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            diag_held.outcome         <= pcds_pkg::OUTCOME_RESET;
            diag_held.short_near_flag <= 1'b0;
            diag_held.fault_count     <= pcds_pkg::FAULT_COUNT_RESET;
        end else if (test_running && diag_done_in) begin
            diag_held <= diag_in;
        end
    end

    // special register writable bits
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            force_link   <= 1'b0;
            pwr_save_off <= pcds_pkg::PWR_SAVE_OFF_RESET;
            remote_loop  <= 1'b0;
            reserved_bit <= 1'b0;
        end else if (wr_special) begin
            force_link   <= wdata_in[pcds_pkg::SPEC_FORCE_LINK_POS];
            pwr_save_off <= wdata_in[pcds_pkg::SPEC_PWR_SAVE_OFF_POS];
            remote_loop  <= wdata_in[pcds_pkg::SPEC_REMOTE_LOOP_POS];
            reserved_bit <= wdata_in[pcds_pkg::SPEC_RESERVED_POS];
        end
    end

    // controls toward the phy
    always_comb begin
        ctrl_out.force_link      = force_link;
        ctrl_out.power_save_en   = ~pwr_save_off;
        ctrl_out.remote_loopback = remote_loop;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, unmapped registers read zero
    always_comb begin
        rd_data_out = 16'h0000;
        unique case (register_select_in)
            pcds_pkg::REG_PARTNER: begin
                rd_data_out[pcds_pkg::PARTNER_PAUSE_POS] = status_in.partner_pause;
                rd_data_out[pcds_pkg::PARTNER_ABIL_LSB +: 4] = status_in.partner_abil;
            end
            pcds_pkg::REG_CABLE_DIAG: begin
                rd_data_out[pcds_pkg::DIAG_START_POS]       = test_running;
                rd_data_out[pcds_pkg::DIAG_OUTCOME_LSB +: 2] = diag_held.outcome;
                rd_data_out[pcds_pkg::DIAG_SHORT_POS]       = diag_held.short_near_flag;
                rd_data_out[pcds_pkg::DIAG_COUNT_LSB +: 9]  = diag_held.fault_count;
            end
            pcds_pkg::REG_SPECIAL: begin
                rd_data_out[pcds_pkg::SPEC_POLARITY_POS]     = status_in.pol_reversed;
                rd_data_out[pcds_pkg::SPEC_MDI_POS]          = status_in.mdi_status;
                rd_data_out[pcds_pkg::SPEC_FORCE_LINK_POS]   = force_link;
                rd_data_out[pcds_pkg::SPEC_PWR_SAVE_OFF_POS] = pwr_save_off;
                rd_data_out[pcds_pkg::SPEC_REMOTE_LOOP_POS]  = remote_loop;
                rd_data_out[pcds_pkg::SPEC_RESERVED_POS]     = reserved_bit;
            end
            default: begin
                rd_data_out = 16'h0000;
            end
        endcase
    end

endmodule
`default_nettype wire

// ---- pcds_mgmt_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcds_mgmt_top (
    input  wire logic                        ref_clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        mdc_in,
    input  wire logic                        mdio_in,
    output logic                             mdio_out,
    output logic                             mdio_oe_out,
    input  wire pcds_pkg::pcds_status_s [1:0] phy_status_in,
    input  wire pcds_pkg::pcds_diag_s   [1:0] diag_result_in,
    input  wire logic [1:0]                  diag_done_in,
    output logic [1:0]                       diag_start_out,
    output pcds_pkg::pcds_ctrl_s        [1:0] phy_ctrl_out
);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_OP    = 3'b010,
        ST_ADDR  = 3'b011,
        ST_TA    = 3'b100,
        ST_DATA  = 3'b101
    } pcds_frame_e;

    pcds_frame_e  state;
    logic         mdc_prev;
    logic         mdc_rise;
    logic [5:0]   pre_cnt;
    logic [4:0]   bit_cnt;
    logic [1:0]   op_code;
    logic [9:0]   addr_sr;
    logic [4:0]   phy_select;
    logic [4:0]   register_select;
    logic         phy_hit;
    logic         phy_index;
    logic [15:0]  rd_sr;
    logic [15:0]  wr_sr;
    logic         wr_pulse;
    logic [15:0]  bank_rd [2];
    logic [1:0]   bank_wr;
    logic [9:0]   next_addr;
    logic [4:0]   next_phy;

    ////////////////////////////////////////////////////////////////////////////
    // mdc edge detection; mdc is sampled as an ordinary synchronous input
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mdc_prev <= 1'b0;
        end else begin
            mdc_prev <= mdc_in;
        end
    end

    assign mdc_rise  = mdc_in & ~mdc_prev;
    assign next_addr = {addr_sr[8:0], mdio_in};
    assign next_phy  = next_addr[9:5];

    // latched address decode
    assign phy_hit   = (phy_select == pcds_pkg::PHY_ADDR_1) ||
                       (phy_select == pcds_pkg::PHY_ADDR_2);
    assign phy_index = (phy_select == pcds_pkg::PHY_ADDR_2);

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state   <= ST_IDLE;
            pre_cnt <= 6'h00;
            bit_cnt <= 5'h00;
        end else if (mdc_rise) begin
            unique case (state)
                ST_IDLE: begin
                    if (mdio_in) begin
                        if (pre_cnt != pcds_pkg::PREAMBLE_LEN) begin
                            pre_cnt <= pre_cnt + 6'h01;
                        end
                    end else begin
                        // zero after a full preamble is the first start bit
                        if (pre_cnt == pcds_pkg::PREAMBLE_LEN) begin
                            state <= ST_START;
                        end
                        pre_cnt <= 6'h00;
                    end
                end
                ST_START: begin
                    state   <= mdio_in ? ST_OP : ST_IDLE;
                    bit_cnt <= 5'h00;
                end
                ST_OP: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == pcds_pkg::OP_BITS - 5'h01) begin
                        state   <= ST_ADDR;
                        bit_cnt <= 5'h00;
                    end
                end
                ST_ADDR: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == pcds_pkg::ADDR_BITS - 5'h01) begin
                        bit_cnt <= 5'h00;
                        // unknown opcodes abandon the frame
                        if ((op_code == pcds_pkg::OP_READ) || (op_code == pcds_pkg::OP_WRITE)) begin
                            state <= ST_TA;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_TA: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'h01) begin
                        state   <= ST_DATA;
                        bit_cnt <= 5'h00;
                    end
                end
                ST_DATA: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == pcds_pkg::DATA_BITS - 5'h01) begin
                        state   <= ST_IDLE;
                        bit_cnt <= 5'h00;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // opcode and address capture
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            op_code         <= 2'h0;
            addr_sr         <= 10'h000;
            phy_select      <= 5'h00;
            register_select <= 5'h00;
        end else if (mdc_rise) begin
            if (state == ST_OP) begin
                op_code <= {op_code[0], mdio_in};
            end
            if (state == ST_ADDR) begin
                addr_sr <= next_addr;
                if (bit_cnt == pcds_pkg::ADDR_BITS - 5'h01) begin
                    phy_select      <= next_phy;
                    register_select <= next_addr[4:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data shift and pin drive
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_sr       <= 16'h0000;
            mdio_out    <= 1'b0;
            mdio_oe_out <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state)
                ST_TA: begin
                    if (op_code == pcds_pkg::OP_READ && phy_hit) begin
                        if (bit_cnt == 5'h00) begin
                            // second turnaround bit is driven low
                            rd_sr       <= bank_rd[phy_index];
                            mdio_out    <= 1'b0;
                            mdio_oe_out <= 1'b1;
                        end else begin
                            mdio_out <= rd_sr[15];
                            rd_sr    <= {rd_sr[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA: begin
                    if (bit_cnt == pcds_pkg::DATA_BITS - 5'h01) begin
                        mdio_oe_out <= 1'b0;
                        mdio_out    <= 1'b0;
                    end else begin
                        mdio_out <= rd_sr[15];
                        rd_sr    <= {rd_sr[14:0], 1'b0};
                    end
                end
                default: begin
                    mdio_oe_out <= 1'b0;
                    mdio_out    <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write data capture; pulse after the last data bit
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_sr    <= 16'h0000;
            wr_pulse <= 1'b0;
        end else begin
            wr_pulse <= 1'b0;
            if (mdc_rise && state == ST_DATA) begin
                wr_sr <= {wr_sr[14:0], mdio_in};
                if (bit_cnt == pcds_pkg::DATA_BITS - 5'h01) begin
                    wr_pulse <= (op_code == pcds_pkg::OP_WRITE) && phy_hit;
                end
            end
        end
    end

    // route the write to the addressed phy
    assign bank_wr[0] = wr_pulse && !phy_index;
    assign bank_wr[1] = wr_pulse && phy_index;

    ////////////////////////////////////////////////////////////////////////////
    // one register bank per phy
    for (genvar i = 0; i < 2; i++) begin : g_bank
        pcds_phy_bank u_bank (
            .ref_clk_in         (ref_clk_in),
            .rst_in             (rst_in),
            .wr_in              (bank_wr[i]),
            .register_select_in (register_select),
            .wdata_in           (wr_sr),
            .status_in          (phy_status_in[i]),
            .diag_in            (diag_result_in[i]),
            .diag_done_in       (diag_done_in[i]),
            .rd_data_out        (bank_rd[i]),
            .ctrl_out           (phy_ctrl_out[i]),
            .diag_start_out     (diag_start_out[i])
        );
    end

endmodule
`default_nettype wire

// ---- pcds_mgmt_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcds_mgmt_props (
    input wire logic                         ref_clk_in,
    input wire logic                         rst_in,
    input wire logic                         mdc_in,
    input wire logic                         mdio_oe_out,
    input wire logic [1:0]                   diag_done_in,
    input wire logic [1:0]                   diag_start_out,
    input wire pcds_pkg::pcds_ctrl_s [1:0]   phy_ctrl_out
);
    logic       mdc_q;
    logic [4:0] rises;
    logic [1:0] run_q;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////////////
    // mdc rises while the device drives, and tests in flight
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mdc_q <= 1'b0;
            rises <= 5'h00;
            run_q <= 2'h0;
        end else begin
            mdc_q <= mdc_in;
            run_q <= (run_q | diag_start_out) & ~diag_done_in;
            if (!mdio_oe_out) begin
                rises <= 5'h00;
            end else if (mdc_in && !mdc_q) begin
                rises <= rises + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    chk_start_pulse0: assert property (diag_start_out[0] |=> !diag_start_out[0] [*8])
        else $error("phy 1 test start is not a lone pulse");
    chk_start_pulse1: assert property (diag_start_out[1] |=> !diag_start_out[1] [*8])
        else $error("phy 2 test start is not a lone pulse");
    chk_start_idle0: assert property (diag_start_out[0] |-> !run_q[0])
        else $error("phy 1 test relaunched while running");
    chk_start_idle1: assert property (diag_start_out[1] |-> !run_q[1])
        else $error("phy 2 test relaunched while running");
    chk_start_frame: assert property ($rose(|diag_start_out) |->
        $past(mdc_in) || $past(mdc_in, 2) || $past(mdc_in, 3) || $past(mdc_in, 4))
        else $error("test start without a write frame");
    chk_ctrl_write: assert property ($changed(phy_ctrl_out) |->
        $past(mdc_in) || $past(mdc_in, 2) || $past(mdc_in, 3) || $past(mdc_in, 4))
        else $error("phy controls changed without a write");
    chk_pwr_reset: assert property ($fell(rst_in) |->
        phy_ctrl_out == 6'h00 && diag_start_out == 2'h0 && !mdio_oe_out)
        else $error("outputs not at reset values");
    chk_oe_after_rise: assert property ($rose(mdio_oe_out) |->
        $past(mdc_in) || $past(mdc_in, 2) || $past(mdc_in, 3) || $past(mdc_in, 4))
        else $error("drive began away from an mdc rise");
    chk_oe_bounded: assert property (mdio_oe_out |-> rises <= 5'h10)
        else $error("device drove mdio past the data bits");

    cov_test_start: cover property (diag_start_out[1]);
    cov_test_start_first: cover property (diag_start_out[0]);
    cov_read_done: cover property ($fell(mdio_oe_out));
    cov_ctrl_write: cover property ($changed(phy_ctrl_out));
endmodule

bind pcds_mgmt_top pcds_mgmt_props u_props (
    .ref_clk_in     (ref_clk_in),
    .rst_in         (rst_in),
    .mdc_in         (mdc_in),
    .mdio_oe_out    (mdio_oe_out),
    .diag_done_in   (diag_done_in),
    .diag_start_out (diag_start_out),
    .phy_ctrl_out   (phy_ctrl_out)
);
`default_nettype wire

// ---- pcds_station.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcds_station (
    input  wire logic ref_clk_in,
    input  wire logic mdio_dev_in,
    input  wire logic mdio_oe_in,
    output logic      mdc_out,
    output logic      mdio_line_out
);
    logic drv_en;
    logic drv_bit;

    // line level: device, else station, else pull-up
    assign mdio_line_out = mdio_oe_in ? mdio_dev_in : (drv_en ? drv_bit : 1'b1);

    // mdc idles low, line released
    initial begin
        mdc_out = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one mdc period: drive in low half, sample just before the rise
    task automatic clock_bit(input logic en, input logic b, output logic s);
        @(negedge ref_clk_in);
        mdc_out = 1'b0;
        drv_en = en;
        drv_bit = b;
        repeat (4) @(negedge ref_clk_in);
        s = mdio_line_out;
        mdc_out = 1'b1;
        repeat (3) @(negedge ref_clk_in);
    endtask

    // whole frame: preamble, start, op, addresses, turnaround, data
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy_select,
                        input logic [4:0] register_select, input logic [15:0] wdata,
                        output logic [15:0] rdata);
        logic [63:0] f;
        logic        s;
        f = {32'hFFFFFFFF, 2'h1, op, phy_select, register_select, 2'h2, wdata};
        rdata = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            clock_bit(!(op == pcds_pkg::OP_READ && i >= 46), f[63 - i], s);
            if (i >= 48) begin
                rdata = {rdata[14:0], s};
            end
        end
        @(negedge ref_clk_in);
        mdc_out = 1'b0;
        drv_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- pcds_mgmt_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define PCDS_CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module pcds_mgmt_top_tb;
    typedef struct packed {
        logic                   idx;
        pcds_pkg::pcds_status_s st;
        logic [4:0]             rg;
        logic [15:0]            exp;
    } pcds_row_s;

    logic                         ref_clk_in;
    logic                         rst_in;
    logic                         mdc;
    logic                         mdio_line;
    logic                         mdio_dev;
    logic                         mdio_oe;
    pcds_pkg::pcds_status_s [1:0] phy_status;
    pcds_pkg::pcds_diag_s [1:0]   diag_result;
    logic [1:0]                   diag_done;
    logic [1:0]                   diag_start;
    pcds_pkg::pcds_ctrl_s [1:0]   phy_ctrl;
    pcds_pkg::pcds_diag_s         res;
    logic [15:0]                  rd;
    logic [14:0]                  prev;
    int                           mismatches;
    int                           n_tests;
    int                           cycles;
    int                           starts [2];
    pcds_row_s                    rows [7] = '{
        '{1'b0, 7'h68, pcds_pkg::REG_PARTNER, 16'h0540},
        '{1'b1, 7'h17, pcds_pkg::REG_PARTNER, 16'h00A0},
        '{1'b1, 7'h17, pcds_pkg::REG_SPECIAL, 16'h0034},
        '{1'b0, 7'h02, pcds_pkg::REG_SPECIAL, 16'h0024},
        '{1'b0, 7'h7D, pcds_pkg::REG_PARTNER, 16'h05E0},
        '{1'b1, 7'h00, pcds_pkg::REG_CABLE_DIAG, 16'h0000},
        '{1'b0, 7'h00, 5'h00, 16'h0000}};

    pcds_station stn (
        .ref_clk_in    (ref_clk_in),
        .mdio_dev_in   (mdio_dev),
        .mdio_oe_in    (mdio_oe),
        .mdc_out       (mdc),
        .mdio_line_out (mdio_line)
    );

    pcds_mgmt_top dut (
        .ref_clk_in     (ref_clk_in),
        .rst_in         (rst_in),
        .mdc_in         (mdc),
        .mdio_in        (mdio_line),
        .mdio_out       (mdio_dev),
        .mdio_oe_out    (mdio_oe),
        .phy_status_in  (phy_status),
        .diag_result_in (diag_result),
        .diag_done_in   (diag_done),
        .diag_start_out (diag_start),
        .phy_ctrl_out   (phy_ctrl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock, test-start counting and hang limit
    always #10 ref_clk_in = ~ref_clk_in;

    always @(posedge ref_clk_in) begin
        starts[0] += (diag_start[0] === 1'b1);
        starts[1] += (diag_start[1] === 1'b1);
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic end_sim();
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // read frame and compare
    task automatic rd_chk(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] e);
        stn.xfer(pcds_pkg::OP_READ, phy, rg, 16'h0000, rd);
        `PCDS_CHK("read data", e, rd)
    endtask

    // write frame, then let the bank update land
    task automatic wr(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
        logic [15:0] unused;
        stn.xfer(pcds_pkg::OP_WRITE, phy, rg, d, unused);
        repeat (4) @(negedge ref_clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        ref_clk_in = 1'b0;
        rst_in = 1'b1;
        phy_status = '0;
        diag_result = '0;
        diag_done = 2'h0;
        repeat (2) @(negedge ref_clk_in);
        rst_in = 1'b0;
        foreach (rows[i]) begin
            phy_status[rows[i].idx] = rows[i].st;
            rd_chk(rows[i].idx ? 5'h02 : 5'h01, rows[i].rg, rows[i].exp);
        end
        phy_status = '0;
        // absent phy leaves the line pulled up
        rd_chk(5'h03, pcds_pkg::REG_SPECIAL, 16'hFFFF);
        wr(5'h01, pcds_pkg::REG_PARTNER, 16'hFFFF);
        rd_chk(5'h01, pcds_pkg::REG_PARTNER, 16'h0000);
        // reserved bit 0 written as zero
        wr(5'h01, pcds_pkg::REG_SPECIAL, 16'hFFFA);
        rd_chk(5'h01, pcds_pkg::REG_SPECIAL, 16'h000A);
        `PCDS_CHK("phy1 controls", 3'h7, phy_ctrl[0])
        `PCDS_CHK("phy2 controls", 3'h0, phy_ctrl[1])
        wr(5'h03, pcds_pkg::REG_SPECIAL, 16'h0000);
        `PCDS_CHK("stray write", 3'h7, phy_ctrl[0])
        // undefined opcode frame must be abandoned, not written
        stn.xfer(2'h3, 5'h01, pcds_pkg::REG_SPECIAL, 16'h0000, rd);
        `PCDS_CHK("bad opcode", 3'h7, phy_ctrl[0])
        // reset in mid-run
        rst_in = 1'b1;
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        `PCDS_CHK("reset controls", 6'h00, phy_ctrl)
        rd_chk(5'h01, pcds_pkg::REG_SPECIAL, 16'h0004);
        // cable test on phy 2 through every outcome code
        prev = 15'h0000;
        for (int oc = 0; oc < 4; oc++) begin
            res = {2'(oc), oc[0], 9'h100 | 9'(oc)};
            wr(5'h02, pcds_pkg::REG_CABLE_DIAG, 16'h8000);
            `PCDS_CHK("test launched", oc + 1, starts[1])
            diag_result[1] = res;
            rd_chk(5'h02, pcds_pkg::REG_CABLE_DIAG, {1'b1, prev});
            wr(5'h02, pcds_pkg::REG_CABLE_DIAG, 16'h8000);
            `PCDS_CHK("relaunch refused", oc + 1, starts[1])
            diag_done[1] = 1'b1;
            @(negedge ref_clk_in);
            diag_done[1] = 1'b0;
            prev = {res.outcome, res.short_near_flag, 3'h0, res.fault_count};
            rd_chk(5'h02, pcds_pkg::REG_CABLE_DIAG, {1'b0, prev});
        end
        `PCDS_CHK("phy1 idle", 0, starts[0])
        // phy 1: done while idle ignored, read-only bits, zero write keeps test
        diag_result[0] = {pcds_pkg::OUTCOME_FAILED, 1'b1, 9'h1FF};
        diag_done[0] = 1'b1;
        @(negedge ref_clk_in);
        diag_done[0] = 1'b0;
        rd_chk(5'h01, pcds_pkg::REG_CABLE_DIAG, 16'h0000);
        wr(5'h01, pcds_pkg::REG_CABLE_DIAG, 16'hFFFF);
        `PCDS_CHK("phy1 launched", 1, starts[0])
        wr(5'h01, pcds_pkg::REG_CABLE_DIAG, 16'h0000);
        rd_chk(5'h01, pcds_pkg::REG_CABLE_DIAG, 16'h8000);
        diag_done[0] = 1'b1;
        @(negedge ref_clk_in);
        diag_done[0] = 1'b0;
        rd_chk(5'h01, pcds_pkg::REG_CABLE_DIAG, 16'h71FF);
        end_sim();
    end
endmodule
`default_nettype wire
